//--- hw/dtm_door_travel_monitor.sv
// Door travel monitor: per-travel times, energies and peak currents,
// filtered motor dissipation, glass-door force and retry settings.
// Assumes position, current and power inputs synchronous to clk_i.
`include "dtm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Time only uninterrupted normal-operation travels
// - Disqualified travel reports zero time
// - Time from 5 mm off end to 5 mm short
// - Four times: open, close, both without slow part
// - Four energies: open, close, slow start, slow end
// - Disqualified travel reports zero energy
// - Energy window 5 mm off end to 5 mm short
// - Peak current per direction, zero when disturbed
// - Opening peak window 5 mm to slow-10 mm
// - Closing peak window slow-5 mm to 5 mm
// - Continuous mean dissipation, zero after power-up
// - Mean filter time constant 2^21 to 2^22 ticks, about 0.6 to 1.2 hours
// - Mean above permissible flags motor overload
// - Instant input, mechanical, dissipation power on read
// - Counterweight 0-8 kg gives force 150 N plus 10m
// - Flag force outside 150 to 230 N inactive
// - Opening attempts configurable, default 3, zero stops
module dtm_door_travel_monitor #(
   parameter int TICK_CYC = `DTM_TICK_NS / `DTM_CLK_NS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic move_open_i,
   input wire logic move_close_i,
   input wire logic normal_op_i,
   input wire logic disturb_i,
   input wire logic [15:0] door_pos_i,
   input wire logic [15:0] motor_cur_i,
   input wire logic [15:0] p_elec_i,
   input wire logic [15:0] p_mech_i,
   output logic irq_o,
   output logic overload_o,
   output logic [15:0] open_force_o,
   output logic force_inactive_o,
   output logic [3:0] open_attempts_o,
   output logic stop_no_retry_o
);
   localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

   // Inclusive window test on a position
   function automatic logic in_win(input logic [15:0] p, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_win = (p >= lo) && (p <= hi);
   endfunction : in_win

   function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
      sub_sat = (a > b) ? a - b : 16'h0000;
   endfunction : sub_sat

   // Out-of-range weights are clamped so the derived force stays legal
   function automatic logic [3:0] clamp_cwt(input logic [3:0] kg);
      clamp_cwt = (kg > `DTM_CWT_MAX) ? `DTM_CWT_MAX : kg;
   endfunction : clamp_cwt

   logic [16:0] tick_cnt;
   logic tick;
   logic [15:0] door_width;
   logic [7:0] slow_start;
   logic [7:0] slow_end;
   logic [1:0] tau_sel;
   logic [3:0] cwt;
   logic [15:0] perm_diss;
   logic [2:0] status;
   logic [2:0] mask;
   dtm_pkg::dtm_travel_t travel;
   logic valid;
   logic reached;
   logic [31:0] acc [`DTM_NRES];
   logic [31:0] res [`DTM_NRES];
   logic [39:0] mean_acc;
   logic [15:0] mean_diss;
   logic [15:0] p_diss;
   logic [4:0] tau_k;
   logic [`DTM_NRES-1:0] win;
   logic [15:0] ss16;
   logic [15:0] se16;
   logic full_open;
   logic full_close;
   logic at_end;
   logic done_open;
   logic done_close;
   logic bus_req;
   logic bus_wr;
   logic [31:0] rd_mux;
   logic [7:0] res_off;
   logic [4:0] tau_sum;
   logic commit_ok;
   logic [2:0] event_hit;

   assign ss16 = {8'h00, slow_start};
   assign se16 = {8'h00, slow_end};
   // Dissipation saturates at zero when the motor feeds power back
   assign p_diss = sub_sat(p_elec_i, p_mech_i);
   // Refused while ack stands, so a held strobe is answered at most every other cycle
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   assign res_off = wb_adr_i - `DTM_A_RES;

   // Coarse tick keeps accumulators narrow; times and energies are in ms units
   always_ff @(posedge clk_i) begin
      if (rst_i || tick_cnt == TICK_LAST) begin
         tick_cnt <= 17'h00000;
      end else begin
         tick_cnt <= tick_cnt + 17'h00001;
      end
      tick <= !rst_i && (tick_cnt == TICK_LAST);
   end

   // Measurement windows, position 0 is the closed end
   always_comb begin
      full_open = in_win(door_pos_i, `DTM_END_MM, sub_sat(door_width, `DTM_END_MM));
      full_close = full_open;
      win[0] = full_open;
      win[1] = full_close;
      win[2] = full_open && door_pos_i >= ss16;
      win[3] = full_close && door_pos_i >= se16;
      win[4] = full_open;
      win[5] = full_close;
      win[6] = full_open && door_pos_i < ss16;
      win[7] = full_close && door_pos_i < se16;
      win[8] = in_win(door_pos_i, `DTM_END_MM, sub_sat(ss16, `DTM_PEAK_MM));
      win[9] = in_win(door_pos_i, `DTM_END_MM, sub_sat(se16, `DTM_END_MM));
      if (travel == dtm_pkg::DTM_OPENING) begin
         at_end = door_pos_i >= sub_sat(door_width, `DTM_END_MM);
      end else begin
         at_end = door_pos_i <= `DTM_END_MM;
      end
   end

   assign done_open = (travel == dtm_pkg::DTM_OPENING) && !move_open_i;
   assign done_close = (travel == dtm_pkg::DTM_CLOSING) && !move_close_i;
   // A travel that never came near its end stop is not a measurement
   assign commit_ok = valid && (reached || at_end);

   // Travel tracking; a travel counts only if never disturbed and it reached the end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         travel <= dtm_pkg::DTM_IDLE;
         valid <= 1'b0;
         reached <= 1'b0;
      end else begin
         unique case (travel)
            dtm_pkg::DTM_IDLE: begin
               valid <= normal_op_i && !disturb_i;
               reached <= 1'b0;
               if (move_open_i) begin
                  travel <= dtm_pkg::DTM_OPENING;
               end else if (move_close_i) begin
                  travel <= dtm_pkg::DTM_CLOSING;
               end
            end
            dtm_pkg::DTM_OPENING, dtm_pkg::DTM_CLOSING: begin
               if (disturb_i || !normal_op_i) begin
                  valid <= 1'b0;
               end
               if (at_end) begin
                  reached <= 1'b1;
               end
               if (done_open || done_close) begin
                  travel <= dtm_pkg::DTM_IDLE;
               end
            end
            default: begin
               travel <= dtm_pkg::DTM_IDLE;
               valid <= 1'b0;
            end
         endcase
      end
   end

   // One accumulator and one held result per measurement
   // Even index belongs to opening, odd index to closing
   for (genvar g = 0; g < `DTM_NRES; g++) begin : g_res
      localparam bit OPEN_DIR = (g % 2 == 0);
      logic dir_hit;
      logic dir_done;
      assign dir_hit = win[g] && (OPEN_DIR ? (travel == dtm_pkg::DTM_OPENING) :
                                             (travel == dtm_pkg::DTM_CLOSING));
      assign dir_done = OPEN_DIR ? done_open : done_close;
      // Cleared in idle, so a result never mixes two travels
      always_ff @(posedge clk_i) begin
         if (rst_i || travel == dtm_pkg::DTM_IDLE) begin
            acc[g] <= 32'h00000000;
         end else if (dir_hit) begin
            if (g >= 8) begin
               if ({16'h0000, motor_cur_i} > acc[g]) begin
                  acc[g] <= {16'h0000, motor_cur_i};
               end
            end else if (g < 4) begin
               if (tick) begin
                  acc[g] <= acc[g] + 32'h00000001;
               end
            end else if (tick) begin
               acc[g] <= acc[g] + {16'h0000, p_mech_i};
            end
         end
      end
      // Commit at travel end; results stay until the next travel of that direction
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            res[g] <= 32'h00000000;
         end else if (dir_done) begin
            res[g] <= commit_ok ? acc[g] : 32'h00000000;
         end
      end
   end

   // Exponential mean of dissipation; reset is the power-up that clears it
   // Clamp keeps every selection inside the permitted time constant span
   assign tau_sum = `DTM_TAU_MIN + {3'b000, tau_sel};
   assign tau_k = (tau_sum > `DTM_TAU_MAX) ? `DTM_TAU_MAX : tau_sum;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mean_acc <= 40'h0000000000;
      end else if (tick) begin
         mean_acc <= mean_acc - (mean_acc >> tau_k) + {24'h000000, p_diss};
      end
   end
   assign mean_diss = 16'(mean_acc >> tau_k);

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         door_width <= `DTM_WIDTH_RST;
         slow_start <= `DTM_SLOW_RST;
         slow_end <= `DTM_SLOW_RST;
         tau_sel <= 2'h0;
         cwt <= 4'h0;
         open_force_o <= `DTM_FORCE_BASE;
         open_attempts_o <= `DTM_ATT_RST;
         perm_diss <= 16'hFFFF;
         mask <= 3'h0;
      end else if (bus_wr) begin
         unique case (wb_adr_i)
            `DTM_A_GEOM: door_width <= wb_dat_i[15:0];
            `DTM_A_SLOW: begin
               slow_start <= wb_dat_i[7:0];
               slow_end <= wb_dat_i[15:8];
            end
            `DTM_A_TAU: tau_sel <= wb_dat_i[1:0];
            `DTM_A_CWT: begin
               cwt <= clamp_cwt(wb_dat_i[3:0]);
               open_force_o <= `DTM_FORCE_BASE +
                  `DTM_FORCE_STEP * {12'h000, clamp_cwt(wb_dat_i[3:0])};
            end
            `DTM_A_FORCE: open_force_o <= wb_dat_i[15:0];
            `DTM_A_ATT: open_attempts_o <= wb_dat_i[3:0];
            `DTM_A_PERM: perm_diss <= wb_dat_i[15:0];
            `DTM_A_MASK: mask <= wb_dat_i[2:0];
            default: ;
         endcase
      end
   end

   // Event sources, one per status bit
   assign event_hit[`DTM_ST_OPEN] = done_open;
   assign event_hit[`DTM_ST_CLOSE] = done_close;
   assign event_hit[`DTM_ST_OVL] = mean_diss > perm_diss;

   // Sticky events; a new event in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= 3'h0;
      end else begin
         for (int b = 0; b < 3; b++) begin
            if (event_hit[b]) begin
               status[b] <= 1'b1;
            end else if (bus_wr && wb_adr_i == `DTM_A_STAT && wb_dat_i[b]) begin
               status[b] <= 1'b0;
            end
         end
      end
   end

   // Flags are registered so every output comes from a flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         overload_o <= 1'b0;
         force_inactive_o <= 1'b0;
         stop_no_retry_o <= 1'b0;
      end else begin
         irq_o <= |(status & mask);
         overload_o <= mean_diss > perm_diss;
         force_inactive_o <= open_force_o < `DTM_FORCE_BASE ||
                             open_force_o > `DTM_FORCE_MAX;
         stop_no_retry_o <= open_attempts_o == 4'h0;
      end
   end

   // Read mux; instantaneous powers are sampled at the access itself
   // Unmapped addresses read as zero and are still answered
   always_comb begin
      rd_mux = 32'h00000000;
      if (wb_adr_i >= `DTM_A_RES && wb_adr_i < `DTM_A_PEL && wb_adr_i[1:0] == 2'b00) begin
         rd_mux = res[res_off[5:2]];
      end else begin
         unique case (wb_adr_i)
            `DTM_A_GEOM: rd_mux = {16'h0000, door_width};
            `DTM_A_SLOW: rd_mux = {16'h0000, slow_end, slow_start};
            `DTM_A_TAU: rd_mux = {30'h00000000, tau_sel};
            `DTM_A_CWT: rd_mux = {28'h0000000, cwt};
            `DTM_A_FORCE: rd_mux = {15'h0000, force_inactive_o, open_force_o};
            `DTM_A_ATT: rd_mux = {28'h0000000, open_attempts_o};
            `DTM_A_PERM: rd_mux = {16'h0000, perm_diss};
            `DTM_A_STAT: rd_mux = {29'h00000000, status};
            `DTM_A_MASK: rd_mux = {29'h00000000, mask};
            `DTM_A_PEL: rd_mux = {16'h0000, p_elec_i};
            `DTM_A_PMECH: rd_mux = {16'h0000, p_mech_i};
            `DTM_A_PDISS: rd_mux = {16'h0000, p_diss};
            `DTM_A_PMEAN: rd_mux = {16'h0000, mean_diss};
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   // Single-cycle slave: ack one edge after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
      end
   end
endmodule : dtm_door_travel_monitor
`default_nettype wire

//--- hw/dtm_cfg.svh
// Offsets, field positions, reset values and timing for the door travel monitor.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH
`define DTM_CLK_NS 8
`define DTM_TICK_NS 1000000
`define DTM_END_MM 16'h0005
`define DTM_PEAK_MM 16'h000A
`define DTM_FORCE_BASE 16'h0096
`define DTM_FORCE_MAX 16'h00E6
`define DTM_FORCE_STEP 16'h000A
`define DTM_CWT_MAX 4'h8
`define DTM_ATT_RST 4'h3
`define DTM_TAU_MIN 5'h15
`define DTM_TAU_MAX 5'h16
`define DTM_WIDTH_RST 16'h0320
`define DTM_SLOW_RST 8'h28
`define DTM_A_GEOM 8'h00
`define DTM_A_SLOW 8'h04
`define DTM_A_TAU 8'h08
`define DTM_A_CWT 8'h0C
`define DTM_A_FORCE 8'h10
`define DTM_A_ATT 8'h14
`define DTM_A_PERM 8'h18
`define DTM_A_STAT 8'h1C
`define DTM_A_MASK 8'h20
`define DTM_A_RES 8'h24
`define DTM_A_PEL 8'h4C
`define DTM_A_PMECH 8'h50
`define DTM_A_PDISS 8'h54
`define DTM_A_PMEAN 8'h58
`define DTM_NRES 10
`define DTM_ST_OPEN 0
`define DTM_ST_CLOSE 1
`define DTM_ST_OVL 2
`define DTM_FORCE_OFF_BIT 16
`endif

//--- hw/dtm_pkg.sv
// Types shared by the door travel monitor.
// Assumes dtm_cfg.svh is on the include path.
package dtm_pkg;
   typedef enum logic [1:0] {DTM_IDLE, DTM_OPENING, DTM_CLOSING} dtm_travel_t;
endpackage : dtm_pkg

//--- testbench/dtm_door_travel_monitor_properties.sv
// Port checks for the door travel monitor.
// Assumes it is bound into dtm_door_travel_monitor; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dtm_travel_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic irq_o,
   input wire logic overload_o,
   input wire logic [15:0] open_force_o,
   input wire logic force_inactive_o,
   input wire logic [3:0] open_attempts_o,
   input wire logic stop_no_retry_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("ack is not a one cycle answer");
   property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   a_idle: assert property (p_idle) else $error("ack without request");
   property p_dat; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
   a_dat: assert property (p_dat) else $error("read data outside ack");
   // Two stable cycles let a one cycle lag between force and flag settle
   property p_inact; $stable(open_force_o) [*2] |->
      force_inactive_o == (open_force_o < 16'h0096 || open_force_o > 16'h00E6); endproperty
   a_inact: assert property (p_inact) else $error("force flag wrong");
   property p_stop; $stable(open_attempts_o) [*2] |->
      stop_no_retry_o == (open_attempts_o == 4'h0); endproperty
   a_stop: assert property (p_stop) else $error("stop flag wrong");
   property p_rst; $fell(rst_i) |-> open_attempts_o == 4'h3 && open_force_o == 16'h0096
      && !stop_no_retry_o; endproperty
   a_rst: assert property (p_rst) else $error("setting reset values wrong");
   property p_ovl; $fell(rst_i) |-> !overload_o [*8]; endproperty
   a_ovl: assert property (p_ovl) else $error("overload right after reset");
   property p_irq; $fell(rst_i) |-> !irq_o ##1 !irq_o; endproperty
   a_irq: assert property (p_irq) else $error("interrupt right after reset");
endmodule : dtm_travel_checker
bind dtm_door_travel_monitor dtm_travel_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .irq_o(irq_o), .overload_o(overload_o), .open_force_o(open_force_o),
   .force_inactive_o(force_inactive_o), .open_attempts_o(open_attempts_o),
   .stop_no_retry_o(stop_no_retry_o));
`default_nettype wire

//--- testbench/dtm_drive_model.sv
// Door drive model: moves the door one mm per MM_CYC clocks to an end stop.
// Assumes one go pulse per travel while idle; current follows position.
`timescale 1ns/1ps
`default_nettype none
module dtm_drive_model #(
   parameter int MM_CYC = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic dir_i,
   input wire logic [15:0] width_i,
   output logic move_open_o,
   output logic move_close_o,
   output logic [15:0] pos_o,
   output logic [15:0] cur_o
);
   int cnt;
   logic mv;
   assign mv = move_open_o || move_close_o;
   // Idle drive draws no current, so stale peaks cannot hide
   assign cur_o = mv ? pos_o : 16'h0000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         move_open_o <= 1'b0;
         move_close_o <= 1'b0;
         pos_o <= 16'h0000;
         cnt <= 0;
      end else if (go_i && !mv) begin
         move_open_o <= dir_i;
         move_close_o <= !dir_i;
         cnt <= 0;
      end else if (mv) begin
         cnt <= (cnt == MM_CYC - 1) ? 0 : cnt + 1;
         if (cnt == MM_CYC - 1) begin
            if (pos_o == (move_open_o ? width_i : 16'h0000)) begin
               move_open_o <= 1'b0;
               move_close_o <= 1'b0;
            end else begin
               pos_o <= move_open_o ? pos_o + 16'h0001 : pos_o - 16'h0001;
            end
         end
      end
   end
endmodule : dtm_drive_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the door travel monitor with a drive model.
// Assumes dtm_cfg.svh on the include path; tick shortened to 10 clocks.
`include "dtm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o, overload_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic mo, mc, normal_op_i = 1'b1, disturb_i = 1'b0, go = 1'b0, gdir = 1'b0;
   logic [15:0] pos, cur, p_elec_i = 16'h0009, p_mech_i = 16'h0002, force_o;
   logic inact, stop;
   logic [3:0] att;
   int mismatches = 0, num_checks = 0, cycles = 0;
   initial forever #4 clk_i = ~clk_i;
   dtm_door_travel_monitor #(.TICK_CYC(10)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .move_open_i(mo), .move_close_i(mc), .normal_op_i(normal_op_i), .disturb_i(disturb_i),
      .door_pos_i(pos), .motor_cur_i(cur), .p_elec_i(p_elec_i), .p_mech_i(p_mech_i),
      .irq_o(irq_o), .overload_o(overload_o), .open_force_o(force_o),
      .force_inactive_o(inact), .open_attempts_o(att), .stop_no_retry_o(stop));
   dtm_drive_model #(.MM_CYC(10)) u_drv (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
      .dir_i(gdir), .width_i(16'h0028), .move_open_o(mo), .move_close_o(mc), .pos_o(pos),
      .cur_o(cur));
   task automatic final_report;
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : wb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rchk
   task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      wb(1'b0, a, 32'h0);
      `CHK(q >= lo && q <= hi, 1'b1)
   endtask : rng
   task automatic travel(input logic d, input logic nop, input logic dis);
      @(posedge clk_i);
      normal_op_i <= nop;
      gdir <= d;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      disturb_i <= dis;
      do @(posedge clk_i); while (mo || mc);
      repeat (3) @(posedge clk_i);
      disturb_i <= 1'b0;
      normal_op_i <= 1'b1;
      @(negedge clk_i);
   endtask : travel
   task automatic t_cfg;
      @(negedge clk_i);
      `CHK(att, 4'h3)
      `CHK(overload_o, 1'b0)
      rchk(`DTM_A_PMEAN, 32'h0);
      rchk(8'h60, 32'h0);
      wb(1'b1, `DTM_A_TAU, 32'h3);
      rchk(`DTM_A_TAU, 32'h3);
      wb(1'b1, `DTM_A_CWT, 32'hC);
      `CHK(force_o, 16'h00E6)
      `CHK(inact, 1'b0)
      wb(1'b1, `DTM_A_CWT, 32'h3);
      `CHK(force_o, 16'h00B4)
      wb(1'b1, `DTM_A_FORCE, 32'h12C);
      `CHK(inact, 1'b1)
      rchk(`DTM_A_FORCE, 32'h1012C);
      wb(1'b1, `DTM_A_FORCE, 32'h95);
      `CHK(inact, 1'b1)
      wb(1'b1, `DTM_A_ATT, 32'h0);
      `CHK(stop, 1'b1)
      wb(1'b1, `DTM_A_ATT, 32'h5);
      `CHK({att, stop}, 5'h0A)
   endtask : t_cfg
   task automatic t_travel;
      wb(1'b1, `DTM_A_GEOM, 32'h28);
      wb(1'b1, `DTM_A_SLOW, 32'h1414);
      travel(1'b1, 1'b1, 1'b0);
      rng(`DTM_A_RES, 30, 32);
      rng(`DTM_A_RES + 8'h08, 15, 17);
      rng(`DTM_A_RES + 8'h10, 60, 64);
      rchk(`DTM_A_RES + 8'h20, 32'hA);
      travel(1'b0, 1'b1, 1'b0);
      rng(`DTM_A_RES + 8'h04, 30, 32);
      rng(`DTM_A_RES + 8'h14, 60, 64);
      rchk(`DTM_A_RES + 8'h24, 32'hF);
      `CHK(irq_o, 1'b0)
      travel(1'b1, 1'b0, 1'b0);
      rchk(`DTM_A_RES, 32'h0);
      rchk(`DTM_A_RES + 8'h10, 32'h0);
      rng(`DTM_A_RES + 8'h04, 30, 32);
      travel(1'b0, 1'b1, 1'b1);
      rchk(`DTM_A_RES + 8'h04, 32'h0);
      rchk(`DTM_A_RES + 8'h14, 32'h0);
      rchk(`DTM_A_RES + 8'h24, 32'h0);
   endtask : t_travel
   task automatic t_irq;
      wb(1'b1, `DTM_A_MASK, 32'h1);
      `CHK(irq_o, 1'b1)
      wb(1'b1, `DTM_A_STAT, 32'h3);
      `CHK(irq_o, 1'b0)
      rchk(`DTM_A_STAT, 32'h0);
   endtask : t_irq
   task automatic t_pow;
      rchk(`DTM_A_PEL, 32'h9);
      rchk(`DTM_A_PDISS, 32'h7);
      @(posedge clk_i);
      p_mech_i <= 16'h000C;
      rchk(`DTM_A_PMECH, 32'hC);
      rchk(`DTM_A_PDISS, 32'h0);
   endtask : t_pow
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_cfg();
      t_travel();
      t_irq();
      t_pow();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
